// [design/i2c_pkg.sv]
// Shared constants and types of the two-wire host port, both ends.
package i2c_pkg;

  // ********************************************************************
  // Bus addresses, pointer reset and byte constants
  // ********************************************************************
  localparam logic [7:0] WR_ADDR_STRAP_LO = 8'hb8;
  localparam logic [7:0] WR_ADDR_STRAP_HI = 8'hba;
  localparam logic [7:0] RD_ADDR_STRAP_LO = 8'hb9;
  localparam logic [7:0] RD_ADDR_STRAP_HI = 8'hbb;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] NOWAIT_FIRST_REG = 8'h90;
  localparam int BYTE_BITS = 8;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_RATE_KBPS = 400;
  localparam int SCL_HALF_NS = 1000000 / BIT_RATE_KBPS / 2;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int STRETCH_US = 64;
  localparam int STRETCH_CYC = (STRETCH_US * 1000 + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    CMD_START,
    CMD_WRITE,
    CMD_READ,
    CMD_STOP
  } cmd_t;

endpackage

// [design/i2c_if.sv]
// Open-drain two-wire bus joining the controller end and the device end.
`timescale 1ns/1ps
`default_nettype none
interface i2c_if;
  // An enable low means that party pulls the line to its output level.
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic d_scl_out;
  logic d_scl_oe;
  logic d_sda_out;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // Pull-ups make a released line high.
  assign scl = (m_scl_oe | m_scl_out) & (d_scl_oe | d_scl_out);
  assign sda = (m_sda_oe | m_sda_out) & (d_sda_oe | d_sda_out);

  modport ctrl (
    output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe,
    input scl, sda
  );
  modport dev (
    output d_scl_out, d_scl_oe, d_sda_out, d_sda_oe,
    input scl, sda
  );
endinterface
`default_nettype wire

// [design/i2c_target.sv]
// Device end: target-only two-wire port onto the control registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [R1] Target only, never starts or clocks
// [R2] Strap sampled once after power-up
// [R3] Write address B8h or BAh by strap
// [R4] Read address B9h or BBh by strap
// [R5] Works at any rate to 400 kbit/s
// [R6] Data changes only while clock low
// [R7] Start and stop seen with clock high
// [R8] Eight bits MSB first, then acknowledge
// [R9] Controller clocks every acknowledge slot
// [R10] Bursts unlimited until controller stops
// [R11] Acknowledge address, subaddress, each data
// [R12] Burst writes advance register address
// [R13] Subaddress kept as read pointer
// [R14] Read bytes from pointer, advancing each
// [R15] Controller not-acknowledges last read byte
// [R16] Hold clock low while busy
// [R17] Low registers need wait before stop
// [R18] Unmatched address left unacknowledged, ignored
// [R19] After not-acknowledge, release until start
// [R20] Start or stop aborts current byte
module i2c_target
  import i2c_pkg::*;
#(
  parameter int STRETCH = STRETCH_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic bus_addr_strap_in,
  input wire logic [7:0] rd_data_in,
  output logic [7:0] rd_addr_out,
  output logic wr_en_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  i2c_if.dev bus
);

  localparam int SW = $clog2(STRETCH + 1);

  generate
    if (STRETCH < 1 || STRETCH > 4096) begin : g_bad
      $error("STRETCH out of range");
    end
  endgenerate

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_W, ST_SUB, ST_ACK_SUB, ST_WDATA,
    ST_ACK_DATA, ST_LOAD, ST_RDATA, ST_RACK, ST_IGNORE
  } dev_state_t;

  // ********************************************************************
  // Input synchronisers and strap capture
  // ********************************************************************
  logic scl_s1_q, scl_s2_q, scl_p_q;
  logic sda_s1_q, sda_s2_q, sda_p_q;
  logic strap_s1_q, strap_s2_q, strap_q, strap_done_q;
  logic strap_d, strap_done_d;

  // [R5] two-flop pin sampling
  // The samplers run through reset so the strap level is ready at release.
  always_ff @(posedge clk_in) begin
    scl_s1_q <= bus.scl;
    scl_s2_q <= scl_s1_q;
    scl_p_q <= scl_s2_q;
    sda_s1_q <= bus.sda;
    sda_s2_q <= sda_s1_q;
    sda_p_q <= sda_s2_q;
    strap_s1_q <= bus_addr_strap_in;
    strap_s2_q <= strap_s1_q;
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] wr_match, rd_match;

  assign scl_rise = scl_s2_q & ~scl_p_q;
  assign scl_fall = ~scl_s2_q & scl_p_q;
  // [R7] conditions with clock high
  assign start_seen = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_seen = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  // [R3] write address select
  assign wr_match = strap_q ? WR_ADDR_STRAP_HI : WR_ADDR_STRAP_LO;
  // [R4] read address select
  assign rd_match = strap_q ? RD_ADDR_STRAP_HI : RD_ADDR_STRAP_LO;

  // ********************************************************************
  // Bus state machine
  // ********************************************************************
  dev_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic pend_q, pend_d, wr_en_q, wr_en_d;
  logic [SW-1:0] stretch_q, stretch_d;
  logic [7:0] wr_addr_q, wr_addr_d, wr_data_q, wr_data_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    sda_oe_d = sda_oe_q;
    scl_oe_d = scl_oe_q;
    pend_d = pend_q;
    stretch_d = stretch_q;
    wr_en_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    strap_d = strap_q;
    strap_done_d = 1'b1;
    // [R2] one-time strap capture
    if (!strap_done_q) begin
      strap_d = strap_s2_q;
    end
    // [R16] clock held low while busy
    if (stretch_q != '0) begin
      stretch_d = stretch_q - 1'b1;
      scl_oe_d = (stretch_q == SW'(1));
    end
    // [R20] start or stop aborts
    if (start_seen) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      sda_oe_d = 1'b1;
    end else if (stop_seen) begin
      st_d = ST_IDLE;
      cnt_d = 4'h0;
      sda_oe_d = 1'b1;
    end else begin
      case (st_q)
        ST_ADDR, ST_SUB, ST_WDATA: begin
          // [R8] shift in MSB first
          if (scl_rise && cnt_q < 4'(BYTE_BITS)) begin
            sh_d = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
          end
          // [R6] drive only after clock falls
          if (scl_fall && cnt_q == 4'(BYTE_BITS)) begin
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
            if (st_q == ST_ADDR) begin
              // [R11] acknowledge own address
              if (sh_q == wr_match) begin
                st_d = ST_ACK_W;
              end else if (sh_q == rd_match) begin
                st_d = ST_LOAD;
              end else begin
                // [R18] foreign address ignored
                sda_oe_d = 1'b1;
                st_d = ST_IGNORE;
              end
            end else if (st_q == ST_SUB) begin
              // [R13] subaddress becomes pointer
              ptr_d = sh_q;
              st_d = ST_ACK_SUB;
            end else begin
              // [R12] store then advance
              wr_en_d = 1'b1;
              wr_addr_d = ptr_q;
              wr_data_d = sh_q;
              ptr_d = ptr_q + 8'h01;
              pend_d = (ptr_q < NOWAIT_FIRST_REG);
              st_d = ST_ACK_DATA;
            end
          end
        end
        ST_ACK_W, ST_ACK_SUB: begin
          if (scl_fall) begin
            sda_oe_d = 1'b1;
            st_d = (st_q == ST_ACK_W) ? ST_SUB : ST_WDATA;
          end
        end
        ST_ACK_DATA: begin
          // [R10] keep taking bytes
          if (scl_fall) begin
            sda_oe_d = 1'b1;
            st_d = ST_WDATA;
            // [R17] wait after low registers
            if (pend_q) begin
              stretch_d = SW'(STRETCH);
              scl_oe_d = 1'b0;
              pend_d = 1'b0;
            end
          end
        end
        ST_LOAD: begin
          // [R14] load byte at pointer
          if (scl_fall) begin
            sh_d = rd_data_in;
            sda_oe_d = rd_data_in[7];
            ptr_d = ptr_q + 8'h01;
            cnt_d = 4'h0;
            st_d = ST_RDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == 4'(BYTE_BITS - 1)) begin
              sda_oe_d = 1'b1;
              cnt_d = 4'h0;
              st_d = ST_RACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_oe_d = sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          // [R19] not-acknowledge ends driving
          if (scl_rise) begin
            st_d = sda_s2_q ? ST_IGNORE : ST_LOAD;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= PTR_RESET;
      sda_oe_q <= 1'b1;
      scl_oe_q <= 1'b1;
      pend_q <= 1'b0;
      stretch_q <= '0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      strap_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      pend_q <= pend_d;
      stretch_q <= stretch_d;
      wr_en_q <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      strap_q <= strap_d;
      strap_done_q <= strap_done_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // [R1] clock pulled only to stretch
  assign bus.d_scl_out = 1'b0;
  assign bus.d_scl_oe = scl_oe_q;
  assign bus.d_sda_out = 1'b0;
  assign bus.d_sda_oe = sda_oe_q;
  assign rd_addr_out = ptr_q;
  assign wr_en_out = wr_en_q;
  assign wr_addr_out = wr_addr_q;
  assign wr_data_out = wr_data_q;

endmodule
`default_nettype wire

// [design/i2c_controller.sv]
// Controller end: byte-level two-wire bus master driven by commands.
`timescale 1ns/1ps
`default_nettype none
module i2c_controller
  import i2c_pkg::*;
#(
  parameter int HALF = SCL_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire cmd_t cmd_in,
  input wire logic [7:0] wr_byte_in,
  input wire logic nack_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [7:0] rd_byte_out,
  output logic acked_out,
  i2c_if.ctrl bus
);

  // [R5] half period never below rate limit
  generate
    if (HALF < SCL_HALF_CYC || HALF > 31) begin : g_bad
      $error("HALF out of range");
    end
  endgenerate

  typedef enum logic [3:0] {
    M_IDLE,
    M_START_A,
    M_START_B,
    M_START_C,
    M_START_D,
    M_BIT_LOW,
    M_BIT_HIGH,
    M_STOP_A,
    M_STOP_B,
    M_STOP_C
  } mst_state_t;

  // ********************************************************************
  // Synchronisers
  // ********************************************************************
  logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= bus.scl;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  mst_state_t st_q, st_d;
  logic [4:0] tmr_q, tmr_d;
  logic [8:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic [3:0] bit_q, bit_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic rdy_q, rdy_d, done_q, done_d, ack_q, ack_d;
  logic [7:0] rdb_q, rdb_d;
  logic tick;

  assign tick = (tmr_q == 5'h00);

  always_comb begin
    st_d = st_q;
    tmr_d = tick ? tmr_q : tmr_q - 5'h01;
    tx_d = tx_q;
    rx_d = rx_q;
    bit_d = bit_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    rdy_d = rdy_q;
    done_d = 1'b0;
    ack_d = ack_q;
    rdb_d = rdb_q;
    case (st_q)
      M_IDLE: begin
        if (cmd_valid_in && rdy_q) begin
          rdy_d = 1'b0;
          tmr_d = 5'(HALF - 1);
          bit_d = 4'h0;
          case (cmd_in)
            CMD_START: begin
              sda_oe_d = 1'b1;
              st_d = M_START_A;
            end
            CMD_WRITE: begin
              // [R8] byte then released acknowledge
              tx_d = {wr_byte_in, 1'b1};
              sda_oe_d = wr_byte_in[7];
              st_d = M_BIT_LOW;
            end
            CMD_READ: begin
              // [R15] not-acknowledge on last
              tx_d = {8'hff, nack_in};
              sda_oe_d = 1'b1;
              st_d = M_BIT_LOW;
            end
            default: begin
              sda_oe_d = 1'b0;
              st_d = M_STOP_A;
            end
          endcase
        end
      end
      M_START_A: begin
        if (tick) begin
          scl_oe_d = 1'b1;
          tmr_d = 5'(HALF - 1);
          st_d = M_START_B;
        end
      end
      M_START_B, M_STOP_B: begin
        // [R17] stretch sensed before timing high
        if (!scl_s2_q) begin
          tmr_d = 5'(HALF - 1);
        end else if (tick) begin
          tmr_d = 5'(HALF - 1);
          sda_oe_d = (st_q == M_STOP_B);
          st_d = (st_q == M_STOP_B) ? M_STOP_C : M_START_C;
        end
      end
      M_START_C: begin
        if (tick) begin
          scl_oe_d = 1'b0;
          tmr_d = 5'(HALF - 1);
          st_d = M_START_D;
        end
      end
      M_BIT_LOW: begin
        // [R6] data set while clock low
        if (tick) begin
          scl_oe_d = 1'b1;
          tmr_d = 5'(HALF - 1);
          st_d = M_BIT_HIGH;
        end
      end
      M_BIT_HIGH: begin
        if (!scl_s2_q) begin
          tmr_d = 5'(HALF - 1);
        end else if (tick) begin
          // [R9] clock pulse also for acknowledge
          scl_oe_d = 1'b0;
          tmr_d = 5'(HALF - 1);
          if (bit_q == 4'(BYTE_BITS)) begin
            rdb_d = rx_q;
            ack_d = ~sda_s2_q;
            st_d = M_START_D;
          end else begin
            rx_d = {rx_q[6:0], sda_s2_q};
            tx_d = {tx_q[7:0], 1'b1};
            sda_oe_d = tx_q[7];
            bit_d = bit_q + 4'h1;
            st_d = M_BIT_LOW;
          end
        end
      end
      M_STOP_A: begin
        if (tick) begin
          scl_oe_d = 1'b1;
          tmr_d = 5'(HALF - 1);
          st_d = M_STOP_B;
        end
      end
      M_START_D, M_STOP_C: begin
        if (tick) begin
          done_d = 1'b1;
          rdy_d = 1'b1;
          st_d = M_IDLE;
        end
      end
      default: begin
        st_d = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q <= M_IDLE;
      tmr_q <= 5'h00;
      tx_q <= 9'h1ff;
      rx_q <= 8'h00;
      bit_q <= 4'h0;
      scl_oe_q <= 1'b1;
      sda_oe_q <= 1'b1;
      rdy_q <= 1'b1;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      rdb_q <= 8'h00;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      bit_q <= bit_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      rdy_q <= rdy_d;
      done_q <= done_d;
      ack_q <= ack_d;
      rdb_q <= rdb_d;
    end
  end

  assign bus.m_scl_out = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_sda_oe = sda_oe_q;
  assign cmd_ready_out = rdy_q;
  assign done_out = done_q;
  assign rd_byte_out = rdb_q;
  assign acked_out = ack_q;

endmodule
`default_nettype wire

// [test/i2c_port_chk.sv]
// Concurrent checks on the two-wire bus between controller and device.
`timescale 1ns/1ps
`default_nettype none
module i2c_port_chk #(
  parameter int STRETCH = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic m_scl_out,
  input wire logic m_scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic d_scl_out,
  input wire logic d_scl_oe,
  input wire logic d_sda_out,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, first_q, first_d, match_q, match_d, rd_q, rd_d;
  logic nack_q, nack_d, ack_rise;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic [15:0] cnt_q, cnt_d;

  // ******************************************************************
  // Bus tracker
  // ******************************************************************
  // Follows bytes on the wire so that acknowledge slots can be judged.
  assign ack_rise = scl && !scl_q && (bit_q == 4'h8);

  always_comb begin
    sh_d = sh_q;
    bit_d = bit_q;
    first_d = first_q;
    match_d = match_q;
    rd_d = rd_q;
    nack_d = nack_q;
    cnt_d = d_scl_oe ? 16'h0000 : cnt_q + 16'h0001;
    if (scl && scl_q && sda_q && !sda) begin
      bit_d = 4'h0;
      first_d = 1'b1;
      nack_d = 1'b0;
    end else if (scl && !scl_q) begin
      if (bit_q < 4'h8) begin
        sh_d = {sh_q[6:0], sda};
        bit_d = bit_q + 4'h1;
      end else begin
        bit_d = 4'h0;
        first_d = 1'b0;
        if (first_q) begin
          match_d = !sda;
          rd_d = sh_q[0];
        end else if (rd_q && sda) begin
          nack_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      first_q <= 1'b0;
      match_q <= 1'b0;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      sh_q <= sh_d;
      bit_q <= bit_d;
      first_q <= first_d;
      match_q <= match_d;
      rd_q <= rd_d;
      nack_q <= nack_d;
      cnt_q <= cnt_d;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence

  chk_sda_setup: assert property (
    $changed(d_sda_oe) |-> !scl ##1 !scl [*4])
    else $error("device data changed near a clock high phase");
  chk_sda_hold: assert property (
    scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("device data changed while clock high");
  chk_no_clocking: assert property (
    $fell(d_scl_oe) |-> !scl)
    else $error("device pulled clock low during a high phase");
  chk_stretch_len: assert property (
    $rose(d_scl_oe) |-> cnt_q == STRETCH)
    else $error("clock hold low had the wrong length");
  chk_start_release: assert property (
    start_s |-> d_sda_oe [*8])
    else $error("device drove data after a start");
  chk_stop_release: assert property (
    stop_s |-> ##3 (d_sda_oe && d_scl_oe))
    else $error("device still drives after a stop");
  chk_nomatch_noack: assert property (
    ack_rise && first_q && (sh_q[7:2] != 6'b101110) |-> sda)
    else $error("foreign address was acknowledged");
  chk_write_ack: assert property (
    ack_rise && !first_q && match_q && !rd_q |-> !sda)
    else $error("written byte was not acknowledged");
  chk_nack_release: assert property (
    nack_q |-> d_sda_oe)
    else $error("device drove data after a not-acknowledge");
  chk_open_drain: assert property (
    !m_scl_out && !m_sda_out && !d_scl_out && !d_sda_out)
    else $error("a party drove a bus line high");
  chk_clock_by_ctrl: assert property (
    $fell(scl) |-> $fell(m_scl_oe))
    else $error("clock fell without the controller pulling it");
  chk_ack_slot_free: assert property (
    ack_rise && !first_q && !rd_q |-> m_sda_oe)
    else $error("controller drove a write acknowledge slot");
endmodule
`default_nettype wire

// [test/test_video_decoder_i2c_slave_port.sv]
// Self-checking bench: controller end talks to device end over the bus.
`timescale 1ns/1ps
`default_nettype none
module test_video_decoder_i2c_slave_port;
  import i2c_pkg::*;
  localparam int HALF_T = 13;
  localparam int STR_T = 4;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic bus_addr_strap = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_t cmd = CMD_STOP;
  logic [7:0] wr_byte = 8'h00;
  logic nack = 1'b0;
  logic cmd_ready, done, acked, wr_en;
  logic [7:0] rd_byte, rd_addr, wr_addr, wr_data, rd_data, wa, ra;
  logic [7:0] regs [256];
  logic [7:0] ref_mem [256];
  logic [15:0] exp_q [$];
  int ptr;
  int n_fail = 0;
  int cmp_count = 0;
  integer seed = 32'hcef2fd21;

  always #50 clk_in = ~clk_in;

  i2c_if bus_if ();
  i2c_controller #(.HALF(HALF_T)) u_i2c_controller (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .wr_byte_in(wr_byte), .nack_in(nack),
    .cmd_ready_out(cmd_ready), .done_out(done), .rd_byte_out(rd_byte),
    .acked_out(acked), .bus(bus_if));
  i2c_target #(.STRETCH(STR_T)) u_i2c_target (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .bus_addr_strap_in(bus_addr_strap), .rd_data_in(rd_data),
    .rd_addr_out(rd_addr), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data), .bus(bus_if));
  i2c_port_chk #(.STRETCH(STR_T)) chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .m_scl_out(bus_if.m_scl_out), .m_scl_oe(bus_if.m_scl_oe),
    .m_sda_out(bus_if.m_sda_out), .m_sda_oe(bus_if.m_sda_oe),
    .d_scl_out(bus_if.d_scl_out), .d_scl_oe(bus_if.d_scl_oe),
    .d_sda_out(bus_if.d_sda_out), .d_sda_oe(bus_if.d_sda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));

  // Register file behind the device; every write must be one expected.
  assign rd_data = regs[rd_addr];
  always @(posedge clk_in) begin
    if (rst_n_in && wr_en === 1'b1) begin
      check({wr_addr, wr_data}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
      regs[wr_addr] <= wr_data;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Issues one command just after an edge and waits for its completion.
  task automatic do_cmd(input cmd_t c, input logic [7:0] b, input logic nk);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd = c;
    wr_byte = b;
    nack = nk;
    @(posedge clk_in);
    #1;
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 20000) check(16'h0000, 16'h0001);
    check(16'(cmd_ready), 16'h0001);
  endtask

  task automatic wbyte(input logic [7:0] b, input logic ak);
    do_cmd(CMD_WRITE, b, 1'b0);
    check(16'(acked), 16'(ak));
  endtask

  task automatic reset_dut(input logic s);
    rst_n_in = 1'b0;
    bus_addr_strap = s;
    repeat (10) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    bus_addr_strap = !s;
    ptr = 0;
    check(16'(rd_addr), 16'(PTR_RESET));
  endtask

  task automatic write_burst(input logic [7:0] sub, input int n);
    logic [7:0] d;
    do_cmd(CMD_START, 8'h00, 1'b0);
    wbyte(wa, 1'b1);
    wbyte(sub, 1'b1);
    ptr = sub;
    repeat (n) begin
      d = 8'($random(seed));
      ref_mem[ptr] = d;
      exp_q.push_back({8'(ptr), d});
      wbyte(d, 1'b1);
      ptr = (ptr + 1) % 256;
    end
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    check(16'(exp_q.size()), 16'h0000);
  endtask

  task automatic read_burst(input logic [7:0] sub, input int n);
    do_cmd(CMD_START, 8'h00, 1'b0);
    wbyte(wa, 1'b1);
    wbyte(sub, 1'b1);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    ptr = sub;
    do_cmd(CMD_START, 8'h00, 1'b0);
    wbyte(ra, 1'b1);
    for (int i = 0; i < n; i++) begin
      do_cmd(CMD_READ, 8'h00, i == n - 1);
      check(16'(rd_byte), 16'(ref_mem[ptr]));
      ptr = (ptr + 1) % 256;
    end
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    check(16'(rd_addr), 16'(ptr));
  endtask

  task automatic refuse(input logic [7:0] a);
    do_cmd(CMD_START, 8'h00, 1'b0);
    wbyte(a, 1'b0);
    wbyte(8'($random(seed)), 1'b0);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
  endtask

  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'($random(seed));
      ref_mem[i] = regs[i];
    end
    for (int s = 0; s < 2; s++) begin
      reset_dut(s[0]);
      wa = s[0] ? WR_ADDR_STRAP_HI : WR_ADDR_STRAP_LO;
      ra = s[0] ? RD_ADDR_STRAP_HI : RD_ADDR_STRAP_LO;
      write_burst(8'($random(seed)) & 8'h7f, 3);
      write_burst(8'hfe, 3);
      $display("burst write test done, strap %0d", s);
      read_burst(8'hfd, 5);
      read_burst(8'($random(seed)), 2);
      $display("burst read test done, strap %0d", s);
      refuse(wa ^ 8'h02);
      refuse(ra ^ 8'h02);
      refuse(8'($random(seed)) & 8'h7f);
      $display("foreign address test done, strap %0d", s);
    end
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
